/* rtl/ehcirh_top.sv */
// Host status flags and two root hub port control/status registers
// What this block does
// - set doorbell ack when async schedule advances after a doorbell request
// - stopped flag is 0 while run is 1, set once execution stops
// - read-only async empty detect flag at status bit 13
// - status bit 14 mirrors the real periodic schedule state
// - status bit 15 mirrors the real async schedule state
// - port state changes only after power switched on and stable
// - port supply becomes stable within 20 ms after power on
// - bit 0 shows the present attach state of the port
// - attach change sets attach changed; software clears by writing 1
// - enable writes of 1 ignored; set only when reset finds high speed
// - disable by disconnect, fault or software; disabled blocks traffic
// - enable changed set only on device disable; write 1 clears
// - overcurrent now is read-only and follows the over-current input
// - overcurrent changed set on any overcurrent now change; W1C
// - resume force drives resume; J-to-K in suspend sets it and change
// - port state from enable and suspend: 0X off, 10 on, 11 suspended
// - suspend waits for idle transaction, then blocks traffic, senses K
// - writing 1 starts bus reset, writing 0 later ends it
// - bus reset reads 1 until done; high speed then enables port
// - supply switch turns power on and off; over-current clears it
// - routing config 1 clears owner, 0 sets owner; software may write it
// - port change flag set on any change bit or on resume force rising other than by a port write
`timescale 1ns/100ps
module ehcirh_top #(
  parameter logic [21:0] PWR_STABLE_CYCLES =
    22'(ehcirh_pkg::PWR_STABLE_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sched_async_advance,
  input wire logic sched_async_empty,
  input wire logic sched_periodic_active,
  input wire logic sched_async_active,
  input wire logic sched_idle,
  output logic run_cmd,
  output logic periodic_en,
  output logic async_en,
  input wire logic [1:0] port_idle,
  input wire ehcirh_pkg::ehcirh_pins_t [1:0] port_pins,
  output logic [1:0] port_power_on,
  output logic [1:0] port_reset_drive,
  output logic [1:0] port_resume_drive,
  output logic [1:0] port_traffic_ok,
  output logic [1:0] port_companion
);
  logic [31:0] cmd_r, cmd_nxt;
  logic halted_r, halted_nxt;
  logic ack_r, ack_nxt;
  logic chg_sum_r, chg_sum_nxt;
  logic route_r, route_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [31:0] rd_val;
  logic mapped;
  logic wr;
  logic [1:0] port_evt;
  ehcirh_pkg::ehcirh_port_t [1:0] port_q;

  assign wr = psel & penable & pwrite & pready;

  // Read mux and address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      ehcirh_pkg::OFS_HOST_CMD: rd_val = cmd_r;
      ehcirh_pkg::OFS_HOST_STATUS: begin
        rd_val[ehcirh_pkg::ST_PORT_CHANGE] = chg_sum_r;
        rd_val[ehcirh_pkg::ST_DOORBELL_ACK] = ack_r;
        rd_val[ehcirh_pkg::ST_STOPPED] = halted_r;
        rd_val[ehcirh_pkg::ST_ASYNC_EMPTY] = sched_async_empty;
        rd_val[ehcirh_pkg::ST_PERIODIC] = sched_periodic_active;
        rd_val[ehcirh_pkg::ST_ASYNC] = sched_async_active;
      end
      ehcirh_pkg::OFS_PORT0:
        rd_val[13:0] = {port_q[0][10:9], 3'h0, port_q[0][8:0]};
      ehcirh_pkg::OFS_PORT1:
        rd_val[13:0] = {port_q[1][10:9], 3'h0, port_q[1][8:0]};
      ehcirh_pkg::OFS_ROUTING_CFG: rd_val[ehcirh_pkg::ROUTE_BIT] = route_r;
      default: mapped = 1'b0;
    endcase
  end

  // Host command, status and bus answer
  always_comb begin
    cmd_nxt = cmd_r;
    ack_nxt = ack_r;
    chg_sum_nxt = chg_sum_r;
    route_nxt = route_r;
    pready_nxt = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~mapped;
    prdata_nxt = (psel & ~penable & ~pwrite) ? rd_val : 32'h0000_0000;
    if (wr && paddr == ehcirh_pkg::OFS_HOST_CMD) begin
      cmd_nxt = 32'h0000_0000;
      cmd_nxt[ehcirh_pkg::CMD_RUN] = pwdata[ehcirh_pkg::CMD_RUN];
      cmd_nxt[ehcirh_pkg::CMD_PERIODIC_EN] =
        pwdata[ehcirh_pkg::CMD_PERIODIC_EN];
      cmd_nxt[ehcirh_pkg::CMD_ASYNC_EN] = pwdata[ehcirh_pkg::CMD_ASYNC_EN];
      cmd_nxt[ehcirh_pkg::CMD_DOORBELL] = cmd_r[ehcirh_pkg::CMD_DOORBELL] |
        pwdata[ehcirh_pkg::CMD_DOORBELL];
    end
    if (wr && paddr == ehcirh_pkg::OFS_HOST_STATUS) begin
      if (pwdata[ehcirh_pkg::ST_DOORBELL_ACK]) begin
        ack_nxt = 1'b0;
      end
      if (pwdata[ehcirh_pkg::ST_PORT_CHANGE]) begin
        chg_sum_nxt = 1'b0;
      end
    end
    if (wr && paddr == ehcirh_pkg::OFS_ROUTING_CFG) begin
      route_nxt = pwdata[ehcirh_pkg::ROUTE_BIT];
    end
    // Hardware sets come last so they win over a clear
    if (cmd_r[ehcirh_pkg::CMD_DOORBELL] && sched_async_advance) begin
      ack_nxt = 1'b1;
      cmd_nxt[ehcirh_pkg::CMD_DOORBELL] = 1'b0;
    end
    if (|port_evt) begin
      chg_sum_nxt = 1'b1;
    end
    // Halted clears with run and sets once the engine has drained
    if (cmd_nxt[ehcirh_pkg::CMD_RUN]) begin
      halted_nxt = 1'b0;
    end else begin
      halted_nxt = halted_r | sched_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= ehcirh_pkg::CMD_RESET;
      halted_r <= 1'b1;
      ack_r <= 1'b0;
      chg_sum_r <= 1'b0;
      route_r <= ehcirh_pkg::ROUTE_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      halted_r <= halted_nxt;
      ack_r <= ack_nxt;
      chg_sum_r <= chg_sum_nxt;
      route_r <= route_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  assign run_cmd = cmd_r[ehcirh_pkg::CMD_RUN];
  assign periodic_en = cmd_r[ehcirh_pkg::CMD_PERIODIC_EN];
  assign async_en = cmd_r[ehcirh_pkg::CMD_ASYNC_EN];

  for (genvar i = 0; i < ehcirh_pkg::NPORTS; i++) begin : g_port
    localparam logic [7:0] PADDR = 8'(ehcirh_pkg::OFS_PORT0 + 4 * i);
    ehcirh_pkg::ehcirh_port_t p_r, p_nxt;
    ehcirh_pkg::ehcirh_pins_t s1_r, s2_r, s3_r, f_r, f_nxt;
    logic susp_req_r, susp_req_nxt;
    logic rst_end_r, rst_end_nxt;
    logic rst_drv_r, rst_drv_nxt;
    logic ok_r, ok_nxt;
    logic evt_r, evt_nxt;
    logic [ehcirh_pkg::PWR_CNT_W-1:0] pwr_cnt_r, pwr_cnt_nxt;
    logic [ehcirh_pkg::RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
    logic wsel, stable, k_rise;

    always_comb begin
      p_nxt = p_r;
      susp_req_nxt = susp_req_r;
      rst_end_nxt = rst_end_r;
      rst_drv_nxt = rst_drv_r;
      pwr_cnt_nxt = pwr_cnt_r;
      rst_cnt_nxt = rst_cnt_r;
      wsel = wr && paddr == PADDR;
      stable = p_r.supply && pwr_cnt_r == '0;
      // A pin change counts once the second and third stages agree
      f_nxt = f_r;
      if (s2_r.attached == s3_r.attached) f_nxt.attached = s3_r.attached;
      if (s2_r.overcurrent == s3_r.overcurrent) begin
        f_nxt.overcurrent = s3_r.overcurrent;
      end
      if (s2_r.k_state == s3_r.k_state) f_nxt.k_state = s3_r.k_state;
      if (s2_r.high_speed == s3_r.high_speed) begin
        f_nxt.high_speed = s3_r.high_speed;
      end
      k_rise = f_nxt.k_state & ~f_r.k_state;
      // Software side
      if (wsel) begin
        if (pwdata[ehcirh_pkg::PB_ATT_CHG]) p_nxt.att_chg = 1'b0;
        if (pwdata[ehcirh_pkg::PB_EN_CHG]) p_nxt.en_chg = 1'b0;
        if (pwdata[ehcirh_pkg::PB_OC_CHG]) p_nxt.oc_chg = 1'b0;
        p_nxt.supply = pwdata[ehcirh_pkg::PB_SUPPLY];
        p_nxt.owner = pwdata[ehcirh_pkg::PB_OWNER];
        // Only clearing is honoured; software disable raises no change
        if (!pwdata[ehcirh_pkg::PB_ENABLE]) begin
          p_nxt.enable = 1'b0;
          p_nxt.suspend = 1'b0;
          susp_req_nxt = 1'b0;
        end
        if (stable) begin
          if (pwdata[ehcirh_pkg::PB_SUSPEND] && p_r.enable) begin
            susp_req_nxt = 1'b1;
          end
          if (pwdata[ehcirh_pkg::PB_RESUME] && p_r.suspend) begin
            p_nxt.resume = 1'b1;
          end else if (!pwdata[ehcirh_pkg::PB_RESUME] && p_r.resume) begin
            p_nxt.resume = 1'b0;
            p_nxt.suspend = 1'b0;
          end
          if (pwdata[ehcirh_pkg::PB_BUS_RESET] && !p_r.bus_reset) begin
            p_nxt.bus_reset = 1'b1;
            p_nxt.enable = 1'b0;
            p_nxt.suspend = 1'b0;
            p_nxt.resume = 1'b0;
            susp_req_nxt = 1'b0;
            rst_drv_nxt = 1'b1;
            rst_end_nxt = 1'b0;
          end else if (!pwdata[ehcirh_pkg::PB_BUS_RESET] && p_r.bus_reset &&
                       !rst_end_r) begin
            rst_end_nxt = 1'b1;
            rst_drv_nxt = 1'b0;
            rst_cnt_nxt = ehcirh_pkg::RST_CNT_W'(ehcirh_pkg::RST_TAIL_CYC);
          end
        end
      end
      if (wr && paddr == ehcirh_pkg::OFS_ROUTING_CFG) begin
        p_nxt.owner = ~pwdata[ehcirh_pkg::ROUTE_BIT];
      end
      // Hardware side, applied after software so a set wins
      p_nxt.attached = f_nxt.attached;
      if (f_nxt.attached != f_r.attached) begin
        p_nxt.att_chg = 1'b1;
        if (!f_nxt.attached && p_nxt.enable) begin
          p_nxt.enable = 1'b0;
          p_nxt.en_chg = 1'b1;
        end
      end
      if (f_nxt.overcurrent != f_r.overcurrent) begin
        p_nxt.oc_now = f_nxt.overcurrent;
        p_nxt.oc_chg = 1'b1;
      end
      if (f_nxt.overcurrent && p_nxt.supply) begin
        p_nxt.supply = 1'b0;
        if (p_nxt.enable) begin
          p_nxt.enable = 1'b0;
          p_nxt.en_chg = 1'b1;
        end
      end
      // Suspend only takes hold once the current transaction is over
      if (susp_req_nxt && !p_nxt.enable) begin
        susp_req_nxt = 1'b0;
      end else if (susp_req_nxt && port_idle[i]) begin
        p_nxt.suspend = 1'b1;
        susp_req_nxt = 1'b0;
      end
      if (p_r.suspend && p_nxt.suspend && !p_r.resume && k_rise) begin
        p_nxt.resume = 1'b1;
      end
      if (rst_end_r) begin
        if (rst_cnt_r == '0) begin
          p_nxt.bus_reset = 1'b0;
          rst_end_nxt = 1'b0;
          p_nxt.enable = f_nxt.high_speed & p_nxt.attached;
        end else begin
          rst_cnt_nxt = rst_cnt_r - 1'b1;
        end
      end
      // Power off drops enable, suspend, resume and bus reset
      if (!p_nxt.supply) begin
        p_nxt.enable = 1'b0;
        p_nxt.suspend = 1'b0;
        p_nxt.resume = 1'b0;
        p_nxt.bus_reset = 1'b0;
        susp_req_nxt = 1'b0;
        rst_end_nxt = 1'b0;
        rst_drv_nxt = 1'b0;
        pwr_cnt_nxt = '0;
      end else if (!p_r.supply) begin
        pwr_cnt_nxt = PWR_STABLE_CYCLES;
      end else if (pwr_cnt_r != '0) begin
        pwr_cnt_nxt = pwr_cnt_r - 1'b1;
      end
      // 10 is enabled, 11 suspended, 0X disabled
      ok_nxt = p_nxt.enable & ~p_nxt.suspend & ~p_nxt.bus_reset;
      evt_nxt = (p_nxt.att_chg & ~p_r.att_chg) |
                (p_nxt.en_chg & ~p_r.en_chg) |
                (p_nxt.oc_chg & ~p_r.oc_chg) |
                (p_nxt.resume & ~p_r.resume & ~wsel);
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        p_r <= '0;
        p_r.owner <= ehcirh_pkg::OWNER_RESET;
        s1_r <= '0;
        s2_r <= '0;
        s3_r <= '0;
        f_r <= '0;
        susp_req_r <= 1'b0;
        rst_end_r <= 1'b0;
        rst_drv_r <= 1'b0;
        ok_r <= 1'b0;
        evt_r <= 1'b0;
        pwr_cnt_r <= '0;
        rst_cnt_r <= '0;
      end else begin
        p_r <= p_nxt;
        s1_r <= port_pins[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        f_r <= f_nxt;
        susp_req_r <= susp_req_nxt;
        rst_end_r <= rst_end_nxt;
        rst_drv_r <= rst_drv_nxt;
        ok_r <= ok_nxt;
        evt_r <= evt_nxt;
        pwr_cnt_r <= pwr_cnt_nxt;
        rst_cnt_r <= rst_cnt_nxt;
      end
    end

    assign port_q[i] = p_r;
    assign port_evt[i] = evt_r;
    assign port_power_on[i] = p_r.supply;
    assign port_reset_drive[i] = rst_drv_r;
    assign port_resume_drive[i] = p_r.resume;
    assign port_traffic_ok[i] = ok_r;
    assign port_companion[i] = p_r.owner;
  end
endmodule // ehcirh_top

/* common/ehcirh_pkg.sv */
// Shared constants and types for the root hub status and port block
package ehcirh_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_HOST_CMD = 8'h00;
  localparam logic [7:0] OFS_HOST_STATUS = 8'h04;
  localparam logic [7:0] OFS_PORT0 = 8'h08;
  localparam logic [7:0] OFS_PORT1 = 8'h0C;
  localparam logic [7:0] OFS_ROUTING_CFG = 8'h10;
  localparam int NPORTS = 2;
  // Host command bits
  localparam int CMD_RUN = 0;
  localparam int CMD_PERIODIC_EN = 4;
  localparam int CMD_ASYNC_EN = 5;
  localparam int CMD_DOORBELL = 6;
  // Host status bits
  localparam int ST_PORT_CHANGE = 2;
  localparam int ST_DOORBELL_ACK = 5;
  localparam int ST_STOPPED = 12;
  localparam int ST_ASYNC_EMPTY = 13;
  localparam int ST_PERIODIC = 14;
  localparam int ST_ASYNC = 15;
  // Port register bits
  localparam int PB_ATTACHED = 0;
  localparam int PB_ATT_CHG = 1;
  localparam int PB_ENABLE = 2;
  localparam int PB_EN_CHG = 3;
  localparam int PB_OC_NOW = 4;
  localparam int PB_OC_CHG = 5;
  localparam int PB_RESUME = 6;
  localparam int PB_SUSPEND = 7;
  localparam int PB_BUS_RESET = 8;
  localparam int PB_SUPPLY = 12;
  localparam int PB_OWNER = 13;
  localparam int ROUTE_BIT = 0;
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam longint PWR_STABLE_MS = 20;
  localparam longint PWR_STABLE_CYC =
    (PWR_STABLE_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int RST_TAIL_NS = 2000;
  localparam int RST_TAIL_CYC = (RST_TAIL_NS * 1000) / CLK_PERIOD_PS;
  localparam int PWR_CNT_W = 22;
  localparam int RST_CNT_W = 8;
  // Reset values
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic OWNER_RESET = 1'b1;
  localparam logic ROUTE_RESET = 1'b0;

  typedef struct packed {
    logic owner;
    logic supply;
    logic bus_reset;
    logic suspend;
    logic resume;
    logic oc_chg;
    logic oc_now;
    logic en_chg;
    logic enable;
    logic att_chg;
    logic attached;
  } ehcirh_port_t;

  typedef struct packed {
    logic attached;
    logic overcurrent;
    logic k_state;
    logic high_speed;
  } ehcirh_pins_t;
endpackage

/* verif/ehcirh_usb_dev.sv */
// Model of the USB devices attached to the two root ports
`timescale 1ns/100ps
module ehcirh_usb_dev (
  input wire logic [1:0] plug,
  input wire logic [1:0] oc_fault,
  input wire logic [1:0] wake,
  input wire logic [1:0] hs_dev,
  input wire logic [1:0] port_power_on,
  output ehcirh_pkg::ehcirh_pins_t [1:0] port_pins
);
  // An unpowered device cannot show itself on the link
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      port_pins[i].attached = plug[i] & port_power_on[i];
      port_pins[i].overcurrent = oc_fault[i];
      port_pins[i].k_state = wake[i] & port_pins[i].attached;
      port_pins[i].high_speed = hs_dev[i] & port_pins[i].attached;
    end
  end
endmodule // ehcirh_usb_dev

/* verif/ehcirh_assertions.sv */
// Concurrent checks on the ports of the root hub block
`timescale 1ns/100ps
module ehcirh_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_cmd,
  input wire ehcirh_pkg::ehcirh_pins_t [1:0] port_pins,
  input wire logic [1:0] port_power_on,
  input wire logic [1:0] port_reset_drive,
  input wire logic [1:0] port_traffic_ok,
  input wire logic [1:0] port_companion
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence route_s(v);
    psel && penable && pready && pwrite &&
      paddr == ehcirh_pkg::OFS_ROUTING_CFG && pwdata[0] == v;
  endsequence
  ready_in_access_a: assert property (setup_s |=> pready)
    else $error("no ready in access cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (setup_s ##0 paddr > 8'h10 |=> pslverr)
    else $error("unmapped access not refused");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  stopped_run_a: assert property (
    pready && !pwrite && paddr == ehcirh_pkg::OFS_HOST_STATUS &&
      $past(run_cmd) |-> !prdata[ehcirh_pkg::ST_STOPPED])
    else $error("stopped flag set while running");
  reset_blocks_a: assert property (
    port_reset_drive[0] |=> !port_traffic_ok[0])
    else $error("traffic open during bus reset");
  reset_power_a: assert property (
    port_reset_drive[0] |-> port_power_on[0])
    else $error("bus reset on unpowered port");
  oc_shutdown_a: assert property (
    port_pins[0].overcurrent [*8] |-> !port_power_on[0])
    else $error("power kept on over-current");
  route_one_a: assert property (
    route_s(1'b1) |-> ##[1:2] port_companion == 2'b00)
    else $error("owner not cleared by routing");
  route_zero_a: assert property (
    route_s(1'b0) |-> ##[1:2] port_companion == 2'b11)
    else $error("owner not set by routing");
endmodule // ehcirh_assertions

bind ehcirh_top ehcirh_assertions u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .run_cmd, .port_pins, .port_power_on,
  .port_reset_drive, .port_traffic_ok, .port_companion
);

/* verif/ehcirh_top_tb.sv */
// Self-checking bench for the root hub status and port block
`timescale 1ns/100ps
module ehcirh_top_tb;
  typedef struct packed {
    logic [2:0] sch;
    logic w;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] m;
    logic [15:0] x;
    logic e;
  } ehcirh_row_t;
  localparam ehcirh_row_t ROWS [10] = '{
    '{3'h0, 1'b0, 8'h04, 16'h0, 16'hF024, 16'h1000, 1'b0},
    '{3'h1, 1'b0, 8'h04, 16'h0, 16'hE000, 16'h2000, 1'b0},
    '{3'h2, 1'b0, 8'h04, 16'h0, 16'hE000, 16'h4000, 1'b0},
    '{3'h4, 1'b0, 8'h04, 16'h0, 16'hE000, 16'h8000, 1'b0},
    '{3'h0, 1'b0, 8'h08, 16'h0, 16'hFFFF, 16'h2000, 1'b0},
    '{3'h0, 1'b0, 8'h0C, 16'h0, 16'hFFFF, 16'h2000, 1'b0},
    '{3'h0, 1'b0, 8'h14, 16'h0, 16'hFFFF, 16'h0, 1'b1},
    '{3'h0, 1'b1, 8'h14, 16'h5, 16'h0, 16'h0, 1'b1},
    '{3'h0, 1'b1, 8'h08, 16'h4, 16'h0, 16'h0, 1'b0},
    '{3'h0, 1'b0, 8'h08, 16'h0, 16'hFFFF, 16'h0, 1'b0}
  };
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, qe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic sched_async_advance, sched_async_empty, sched_periodic_active;
  logic sched_async_active, sched_idle, run_cmd, periodic_en, async_en;
  logic [1:0] port_idle, plug, oc_fault, wake, hs_dev, port_power_on;
  logic [1:0] port_reset_drive, port_resume_drive, port_traffic_ok;
  logic [1:0] port_companion;
  ehcirh_pkg::ehcirh_pins_t [1:0] port_pins;
  int mismatches, num_checks;

  ehcirh_top #(.PWR_STABLE_CYCLES(22'd16)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sched_async_advance, .sched_async_empty,
    .sched_periodic_active, .sched_async_active, .sched_idle, .run_cmd,
    .periodic_en, .async_en, .port_idle, .port_pins, .port_power_on,
    .port_reset_drive, .port_resume_drive, .port_traffic_ok,
    .port_companion
  );
  ehcirh_usb_dev dev (
    .plug, .oc_fault, .wake, .hs_dev, .port_power_on, .port_pins
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      results();
    end
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // The whole sequence needs about five hundred cycles
  initial begin
    wt(20000);
    mismatches++;
    results();
  end

  initial begin
    {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
    {sched_async_advance, sched_async_empty, sched_idle} = '0;
    {sched_periodic_active, sched_async_active} = '0;
    {port_idle, plug, oc_fault, wake, hs_dev} = '0;
    mismatches = 0;
    num_checks = 0;
    wt(3);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      {sched_async_active, sched_periodic_active, sched_async_empty} <=
        ROWS[i].sch;
      wt(2);
      apb(ROWS[i].w, ROWS[i].a, {16'h0, ROWS[i].d});
      chk(q & {16'h0, ROWS[i].m}, {16'h0, ROWS[i].x});
      chk({31'h0, qe}, {31'h0, ROWS[i].e});
    end
    $display("test table done");
    wr(8'h00, 32'h71);
    sched_async_advance <= 1'b1;
    wt(1);
    sched_async_advance <= 1'b0;
    chk({31'h0, run_cmd}, 32'h1);
    chk({30'h0, periodic_en, async_en}, 32'h3);
    rd(8'h04, 32'h1020, 32'h20);
    wr(8'h04, 32'h20);
    rd(8'h04, 32'h20, 32'h0);
    wr(8'h00, 32'h0);
    rd(8'h04, 32'h1000, 32'h0);
    sched_idle <= 1'b1;
    wt(2);
    rd(8'h04, 32'h1000, 32'h1000);
    sched_idle <= 1'b0;
    wr(8'h00, 32'h31);
    $display("test host done");
    wr(8'h08, 32'h1000);
    wt(2);
    chk({30'h0, port_power_on}, 32'h1);
    plug[0] <= 1'b1;
    hs_dev[0] <= 1'b1;
    wt(8);
    rd(8'h08, 32'h3, 32'h3);
    rd(8'h04, 32'h4, 32'h4);
    wr(8'h08, 32'h1002);
    rd(8'h08, 32'h3, 32'h1);
    wr(8'h04, 32'h4);
    // Software side of bus reset: running, enable written 0
    rd(8'h04, 32'h1000, 32'h0);
    wr(8'h08, 32'h1100);
    wt(2);
    chk({30'h0, port_reset_drive}, 32'h1);
    wr(8'h08, 32'h1000);
    rd(8'h08, 32'h104, 32'h100);
    wt(260);
    rd(8'h08, 32'h104, 32'h4);
    chk({30'h0, port_traffic_ok}, 32'h1);
    $display("test attach done");
    wr(8'h08, 32'h1084);
    rd(8'h08, 32'h84, 32'h4);
    port_idle[0] <= 1'b1;
    wt(3);
    rd(8'h08, 32'h84, 32'h84);
    chk({30'h0, port_traffic_ok}, 32'h0);
    wake[0] <= 1'b1;
    wt(8);
    rd(8'h08, 32'h40, 32'h40);
    rd(8'h04, 32'h4, 32'h4);
    wake[0] <= 1'b0;
    wr(8'h08, 32'h1004);
    rd(8'h08, 32'hC4, 32'h4);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h1084);
    wr(8'h08, 32'h10C4);
    wt(2);
    chk({30'h0, port_resume_drive}, 32'h1);
    rd(8'h04, 32'h4, 32'h0);
    wr(8'h08, 32'h1004);
    $display("test suspend done");
    oc_fault[0] <= 1'b1;
    wt(8);
    rd(8'h08, 32'h103C, 32'h38);
    chk({30'h0, port_power_on}, 32'h0);
    oc_fault[0] <= 1'b0;
    wr(8'h10, 32'h1);
    wt(2);
    chk({30'h0, port_companion}, 32'h0);
    wr(8'h10, 32'h0);
    wt(2);
    chk({30'h0, port_companion}, 32'h3);
    $display("test fault done");
    presetn <= 1'b0;
    wt(3);
    chk({30'h0, port_companion}, 32'h3);
    presetn <= 1'b1;
    rd(8'h04, 32'hFFFF, 32'h1000);
    rd(8'h08, 32'hFFFF, 32'h2000);
    $display("test reset done");
    results();
  end
endmodule // ehcirh_top_tb
